// ---- hw/lmt_top.sv ----
// Mode select, receive monitors and transmit timing of one channel.
// Assumes pins are asynchronous to i_clk and slow beside it.
//
// Contract
// - Select low takes straps; high takes registers only.
// - Rate select high is E4, low STM-1.
// - Media select high is CMI, low NRZ pass-through.
// - Parallel select picks nibble or serial host side.
// - Reference code and rate set frequency; 10 only at STM-1.
// - Monitor enable in CMI mode adds flat gain.
// - No loss detection in local loopback or monitor mode.
// - CMI loss sets and clears after 110 UI past threshold.
// - NRZ loss after 2.3 us quiet; 5 transitions in 32 UI clear.
// - During loss the clock tap holds and data is zero.
// - Lock lost after 420 us off, regained after 500 us on.
// - Serial mode field selects the four serial timing modes.
// - Clock+data mode captures on rising host clock.
// - Data-only mode recovers clock and retimes via FIFO; the logic instead captures on rising host clock.
// - Plesiochronous mode bypasses FIFO and retiming.
// - Parallel mode retimes nibbles through a 4x8 FIFO.
// - Parallel clock mode 0 slave, 1 master; slave loop needs 11.
// - Loop timing retimes on the recovered receive clock.
// - FIFO slip sets error; reset pulse clears and recentres.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lmt_top
  import lmt_pkg::*;
#(
  parameter int LOL_SET = LOL_SET_CYC,
  parameter int LOL_CLR = LOL_CLR_CYC,
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_W = 4
) (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  input  wire logic [AW-1:0]     i_addr,
  input  wire logic [DW-1:0]     i_wr_data,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  output logic      [DW-1:0]     o_rd_data,
  input  wire logic              i_hw_sw_control_select,
  input  wire logic              i_rate_select_pin,
  input  wire logic              i_media_select_pin,
  input  wire logic              i_host_interface_select_pin,
  input  wire logic              i_monitor_strap_pin,
  input  wire logic [1:0]        i_ref_freq_select,
  input  wire logic [1:0]        i_timing_mode_strap,
  input  wire logic              i_loopback_pin,
  input  wire logic              i_tx_fifo_reset_pulse,
  input  wire logic              i_rx_peak_low,
  input  wire logic              i_rx_peak_ok,
  input  wire logic              i_rx_nrz_data,
  input  wire logic              i_rx_freq_err,
  input  wire logic              i_rx_rec_clk,
  input  wire logic              i_synth_clk,
  input  wire logic              i_host_serial_tx_clock,
  input  wire logic              i_host_serial_tx_data,
  input  wire logic [FIFO_W-1:0] i_host_tx_nibble,
  output logic                   o_rx_signal_lost_flag,
  output logic                   o_rx_lock_lost,
  output logic                   o_rx_data,
  output logic                   o_rx_clk_hold,
  output logic                   o_rx_monitor_enable,
  output logic                   o_cmi_enable,
  output logic                   o_rate_e4,
  output logic      [1:0]        o_ref_freq_select,
  output logic                   o_ref_cfg_err,
  output logic      [6:0]        o_timing_mode,
  output logic                   o_tx_retime_rx,
  output logic                   o_tx_fifo_error,
  output logic      [FIFO_W-1:0] o_tx_nibble,
  output logic                   o_tx_nibble_valid
);

  localparam int NA = 20 + FIFO_W;
  localparam int PW = $clog2(FIFO_DEPTH);

  // Refuse sizes the logic cannot serve.
  if (LOL_SET < 1 || LOL_SET >= 2**17 || LOL_CLR < 1 || LOL_CLR >= 2**17) begin : g_chk_lol
    $error("Lock qualification counts must lie in 1 to 131071.");
  end
  if (FIFO_DEPTH != 8 || FIFO_W != 4) begin : g_chk_fifo
    $error("The decoupling FIFO is four bits by eight entries.");
  end

  // Two-flop synchronisers for all pins.
  logic [NA-1:0] async_in;
  logic [NA-1:0] meta_r;
  logic [NA-1:0] sync_r;
  assign async_in = {i_host_tx_nibble, i_host_serial_tx_data, i_host_serial_tx_clock,
                     i_synth_clk, i_rx_rec_clk, i_rx_freq_err, i_rx_nrz_data,
                     i_rx_peak_ok, i_rx_peak_low, i_tx_fifo_reset_pulse, i_loopback_pin,
                     i_timing_mode_strap, i_ref_freq_select, i_monitor_strap_pin,
                     i_host_interface_select_pin, i_media_select_pin, i_rate_select_pin,
                     i_hw_sw_control_select};
  for (genvar g = 0; g < NA; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        meta_r[g] <= 1'b0;
        sync_r[g] <= 1'b0;
      end else if (i_ce) begin
        meta_r[g] <= async_in[g];
        sync_r[g] <= meta_r[g];
      end
    end
  end

  logic              s_hwsw;
  logic              s_frst;
  logic              s_peak_low;
  logic              s_peak_ok;
  logic              s_nrz;
  logic              s_freq_err;
  logic              s_rec_clk;
  logic              s_synth_clk;
  logic              s_tx_clk;
  logic              s_tx_dat;
  logic [1:0]        s_tm_strap;
  logic [FIFO_W-1:0] s_nib;
  lmt_cfg_t          strap_cfg;
  assign s_hwsw      = sync_r[0];
  assign s_tm_strap  = sync_r[8:7];
  assign s_frst      = sync_r[10];
  assign s_peak_low  = sync_r[11];
  assign s_peak_ok   = sync_r[12];
  assign s_nrz       = sync_r[13];
  assign s_freq_err  = sync_r[14];
  assign s_rec_clk   = sync_r[15];
  assign s_synth_clk = sync_r[16];
  assign s_tx_clk    = sync_r[17];
  assign s_tx_dat    = sync_r[18];
  assign s_nib       = sync_r[NA-1:20];

  // Strap view; three-level reference strap maps to 00, 10, 11.
  always_comb begin
    strap_cfg           = '0;
    strap_cfg.rate_e4   = sync_r[1];
    strap_cfg.media_cmi = sync_r[2];
    strap_cfg.par       = sync_r[3];
    strap_cfg.monitor   = sync_r[4];
    strap_cfg.ref_sel   = (sync_r[6:5] == STRAP_HIGH) ? REF_HIGH :
                          (sync_r[6:5] == STRAP_FLT) ? REF_MID : REF_LOW;
    strap_cfg.loopback  = sync_r[9];
  end

  // Control register, written over the register port.
  lmt_cfg_t ctrl_r;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_r <= CTRL_RST;
    end else if (i_ce && i_wr_en && i_addr == REG_CTRL) begin
      ctrl_r <= i_wr_data[10:0];
    end
  end

  // Select straps or registers.
  lmt_cfg_t cfg;
  assign cfg = s_hwsw ? ctrl_r : strap_cfg;

  // Transmit timing mode decode.
  lmt_tmode_t tmode_nxt;
  lmt_tmode_t tmode_r;
  always_comb begin
    tmode_nxt = TM_SYNC_CD;
    if (s_hwsw) begin
      if (cfg.par) begin
        if (cfg.parallel_clock_mode) begin
          tmode_nxt = TM_PAR_MST;
        end else if (cfg.smod == SMOD_LOOP) begin
          tmode_nxt = TM_PAR_SLV_L;
        end else begin
          tmode_nxt = TM_PAR_SLV;
        end
      end else begin
        unique case (cfg.smod)
          SMOD_SYNC_CD: tmode_nxt = TM_SYNC_CD;
          SMOD_SYNC_D:  tmode_nxt = TM_SYNC_D;
          SMOD_PLESIO:  tmode_nxt = TM_PLESIO;
          SMOD_LOOP:    tmode_nxt = TM_LOOP;
        endcase
      end
    end else begin
      unique case (s_tm_strap)
        STRAP_LOW:  tmode_nxt = cfg.par ? TM_PAR_SLV : TM_SYNC_CD;
        STRAP_FLT:  tmode_nxt = cfg.par ? TM_PAR_SLV_L : TM_SYNC_D;
        STRAP_HIGH: tmode_nxt = cfg.par ? TM_PAR_MST : TM_PLESIO;
        default:    tmode_nxt = cfg.par ? TM_PAR_SLV : TM_SYNC_CD;
      endcase
    end
  end

  // Registered mode and configuration outputs.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tmode_r             <= TM_SYNC_CD;
      o_rate_e4           <= 1'b0;
      o_cmi_enable        <= 1'b0;
      o_rx_monitor_enable <= 1'b0;
      o_ref_freq_select   <= REF_LOW;
      o_ref_cfg_err       <= 1'b0;
    end else if (i_ce) begin
      tmode_r             <= tmode_nxt;
      o_rate_e4           <= cfg.rate_e4;
      o_cmi_enable        <= cfg.media_cmi;
      o_rx_monitor_enable <= cfg.media_cmi & cfg.monitor;
      o_ref_freq_select   <= cfg.ref_sel;
      o_ref_cfg_err       <= cfg.rate_e4 & (cfg.ref_sel == REF_MID) |
                             (cfg.ref_sel == 2'h1);
    end
  end
  assign o_timing_mode = tmode_r;

  // Loss of signal from CMI peak or NRZ activity.
  logic [8:0] los_cnt_r;
  logic [5:0] win_cnt_r;
  logic [2:0] trans_r;
  logic       nrz_d_r;
  logic       los_r;
  logic       los_off;
  logic       trans;
  logic [8:0] los_need;
  logic [5:0] win_len;
  assign los_off  = cfg.loopback | (cfg.media_cmi & cfg.monitor);
  assign trans    = s_nrz ^ nrz_d_r;
  assign los_need = cfg.rate_e4 ? 9'(LOS_E4_CYC) : 9'(LOS_STM_CYC);
  assign win_len  = cfg.rate_e4 ? 6'(WIN_E4_CYC) : 6'(WIN_STM_CYC);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      los_r     <= 1'b0;
      los_cnt_r <= '0;
      win_cnt_r <= '0;
      trans_r   <= '0;
      nrz_d_r   <= 1'b0;
    end else if (i_ce) begin
      nrz_d_r <= s_nrz;
      if (los_off) begin
        los_r     <= 1'b0;
        los_cnt_r <= '0;
      end else if (cfg.media_cmi) begin
        // Count cycles that push toward a change.
        if ((!los_r && s_peak_low) || (los_r && s_peak_ok)) begin
          if (los_cnt_r + 9'h001 >= los_need) begin
            los_r     <= ~los_r;
            los_cnt_r <= '0;
          end else begin
            los_cnt_r <= los_cnt_r + 9'h001;
          end
        end else begin
          los_cnt_r <= '0;
        end
      end else if (!los_r) begin
        // Quiet time since the last transition.
        if (trans) begin
          los_cnt_r <= '0;
        end else if (los_cnt_r + 9'h001 >= 9'(QUIET_CYC)) begin
          los_r     <= 1'b1;
          los_cnt_r <= '0;
        end else begin
          los_cnt_r <= los_cnt_r + 9'h001;
        end
      end
      // Count transitions per 32 UI window while lost.
      if (!los_r || cfg.media_cmi || los_off) begin
        win_cnt_r <= '0;
        trans_r   <= '0;
      end else if (trans && trans_r >= NRZ_MIN_TRANS) begin
        los_r     <= 1'b0;
        win_cnt_r <= '0;
        trans_r   <= '0;
      end else if (win_cnt_r + 6'h01 >= win_len) begin
        win_cnt_r <= '0;
        trans_r   <= '0;
      end else begin
        win_cnt_r <= win_cnt_r + 6'h01;
        trans_r   <= trans_r + {2'h0, trans};
      end
    end
  end

  // Squelch data and hold clock while signal is lost.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rx_signal_lost_flag <= 1'b0;
      o_rx_data             <= 1'b0;
      o_rx_clk_hold         <= 1'b0;
    end else if (i_ce) begin
      o_rx_signal_lost_flag <= los_r;
      o_rx_data             <= los_r ? 1'b0 : s_nrz;
      o_rx_clk_hold         <= los_r;
    end
  end

  // Lock detector; a lock control change restarts it.
  logic [16:0] lol_cnt_r;
  logic        lol_r;
  logic        lock_ctl_d_r;
  logic        lol_flip;
  assign lol_flip = lol_r ? ~s_freq_err : s_freq_err;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lol_r        <= 1'b0;
      lol_cnt_r    <= '0;
      lock_ctl_d_r <= 1'b0;
    end else if (i_ce) begin
      lock_ctl_d_r <= ctrl_r.lock_ctl;
      if (lock_ctl_d_r != ctrl_r.lock_ctl) begin
        lol_r     <= 1'b0;
        lol_cnt_r <= '0;
      end else if (!lol_flip) begin
        lol_cnt_r <= '0;
      end else if (lol_cnt_r >= (lol_r ? 17'(LOL_CLR) : 17'(LOL_SET))) begin
        lol_r     <= ~lol_r;
        lol_cnt_r <= '0;
      end else begin
        lol_cnt_r <= lol_cnt_r + 17'h00001;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rx_lock_lost <= 1'b0;
    end else if (i_ce) begin
      o_rx_lock_lost <= lol_r;
    end
  end

  // Edge finders on the synchronised clocks and FIFO reset pulse.
  logic tx_clk_d_r;
  logic rt_clk_d_r;
  logic frst_d_r;
  logic retime_rx;
  logic rt_clk;
  assign retime_rx = (tmode_r == TM_LOOP) || (tmode_r == TM_PAR_SLV_L);
  assign rt_clk    = retime_rx ? s_rec_clk : s_synth_clk;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_clk_d_r <= 1'b0;
      rt_clk_d_r <= 1'b0;
      frst_d_r   <= 1'b0;
    end else if (i_ce) begin
      tx_clk_d_r <= s_tx_clk;
      rt_clk_d_r <= rt_clk;
      frst_d_r   <= s_frst;
    end
  end

  // Serial bits gather into nibbles; parallel nibbles pass.
  logic              tx_rise;
  logic [FIFO_W-1:0] shf_r;
  logic [1:0]        bit_cnt_r;
  logic              nib_rdy_r;
  logic [FIFO_W-1:0] nib_r;
  logic              is_par;
  assign tx_rise = s_tx_clk & ~tx_clk_d_r;
  assign is_par  = tmode_r[4] | tmode_r[5] | tmode_r[6];
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      shf_r     <= '0;
      bit_cnt_r <= '0;
      nib_rdy_r <= 1'b0;
      nib_r     <= '0;
    end else if (i_ce) begin
      nib_rdy_r <= 1'b0;
      if (tx_rise && is_par) begin
        nib_r     <= s_nib;
        nib_rdy_r <= 1'b1;
      end else if (tx_rise) begin
        shf_r     <= {shf_r[FIFO_W-2:0], s_tx_dat};
        bit_cnt_r <= bit_cnt_r + 2'h1;
        if (bit_cnt_r == 2'h3) begin
          nib_r     <= {shf_r[FIFO_W-2:0], s_tx_dat};
          nib_rdy_r <= 1'b1;
        end
      end
    end
  end

  // Decoupling FIFO of eight nibbles.
  logic [FIFO_W-1:0] mem_r [FIFO_DEPTH];
  logic [PW-1:0]     wptr_r;
  logic [PW-1:0]     rptr_r;
  logic [PW:0]       cnt_r;
  logic              fifo_en;
  logic              push;
  logic              pop;
  logic              frst;
  logic              ovf;
  logic              unf;
  assign fifo_en = (tmode_r != TM_PLESIO);
  assign push    = nib_rdy_r & fifo_en;
  assign pop     = rt_clk & ~rt_clk_d_r & fifo_en;
  assign frst    = (s_frst & ~frst_d_r) |
                   (i_wr_en & (i_addr == REG_CMD) & i_wr_data[CMD_FIFO_RST_BIT]);
  assign ovf     = push & ~pop & (cnt_r == 4'(FIFO_DEPTH));
  assign unf     = pop & (cnt_r == '0);

  // FIFO storage writes.
  always_ff @(posedge i_clk) begin
    if (i_ce && push && !ovf) begin
      mem_r[wptr_r] <= nib_r;
    end
  end

  // FIFO pointers; reset recentres at half depth.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wptr_r <= PW'(FIFO_CENTRE);
      rptr_r <= '0;
      cnt_r  <= FIFO_CENTRE;
    end else if (i_ce) begin
      if (frst || !fifo_en) begin
        rptr_r <= wptr_r - PW'(FIFO_CENTRE);
        cnt_r  <= FIFO_CENTRE;
      end else begin
        if (push && !ovf) begin
          wptr_r <= wptr_r + 3'h1;
        end
        if (pop && !unf) begin
          rptr_r <= rptr_r + 3'h1;
        end
        cnt_r <= cnt_r + {3'h0, push & ~ovf} - {3'h0, pop & ~unf};
      end
    end
  end

  // Error flag: a new slip in the cycle of the reset still sets it.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_fifo_error <= 1'b0;
    end else if (i_ce) begin
      o_tx_fifo_error <= (o_tx_fifo_error & ~frst) | ovf | unf;
    end
  end

  // Transmit output from the FIFO, or direct when bypassed.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_nibble       <= '0;
      o_tx_nibble_valid <= 1'b0;
      o_tx_retime_rx    <= 1'b0;
    end else if (i_ce) begin
      o_tx_retime_rx    <= retime_rx;
      o_tx_nibble_valid <= fifo_en ? (pop & ~unf) : nib_rdy_r;
      if (!fifo_en && nib_rdy_r) begin
        o_tx_nibble <= nib_r;
      end else if (pop && !unf) begin
        o_tx_nibble <= mem_r[rptr_r];
      end
    end
  end

  // Reads answer one cycle later; otherwise zero.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data <= '0;
    end else if (i_ce) begin
      o_rd_data <= '0;
      if (i_rd_en) begin
        unique case (i_addr)
          REG_CTRL: o_rd_data <= {5'h00, ctrl_r};
          REG_STAT: o_rd_data <= {12'h000, s_hwsw, o_tx_fifo_error, lol_r, los_r};
          REG_MODE: o_rd_data <= {6'h00, o_ref_cfg_err, cfg.ref_sel, tmode_r};
          REG_CMD:  o_rd_data <= '0;
        endcase
      end
    end
  end

endmodule : lmt_top
`default_nettype wire

// ---- hw/lmt_pkg.sv ----
// Constants, carriers and codes of the mode and monitor block.
// Assumes a 200 MHz clock; times become cycles of it.
package lmt_pkg;
  // Clock and unit intervals, in picoseconds.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int UI_STM_PS     = 6430;
  localparam int UI_E4_PS      = 7181;
  // Signal qualification figures.
  localparam int LOS_UI        = 110;
  localparam int NRZ_WIN_UI    = 32;
  localparam int NRZ_QUIET_NS  = 2300;
  localparam int LOL_SET_US    = 420;
  localparam int LOL_CLR_US    = 500;
  // Least times round up, windows round down.
  localparam int LOS_STM_CYC   = (LOS_UI * UI_STM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOS_E4_CYC    = (LOS_UI * UI_E4_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WIN_STM_CYC   = NRZ_WIN_UI * UI_STM_PS / CLK_PERIOD_PS;
  localparam int WIN_E4_CYC    = NRZ_WIN_UI * UI_E4_PS / CLK_PERIOD_PS;
  localparam int QUIET_CYC     = (NRZ_QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOL_SET_CYC   = LOL_SET_US * 1000000 / CLK_PERIOD_PS;
  localparam int LOL_CLR_CYC   = LOL_CLR_US * 1000000 / CLK_PERIOD_PS;
  localparam logic [2:0] NRZ_MIN_TRANS = 3'h4;
  // Register bus.
  localparam int AW = 2;
  localparam int DW = 16;
  localparam logic [AW-1:0] REG_CTRL = 2'h0;
  localparam logic [AW-1:0] REG_CMD  = 2'h1;
  localparam logic [AW-1:0] REG_STAT = 2'h2;
  localparam logic [AW-1:0] REG_MODE = 2'h3;
  localparam int CMD_FIFO_RST_BIT    = 0;
  localparam logic [10:0] CTRL_RST   = 11'h000;
  // Three-level strap codes.
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_FLT  = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  // Serial timing mode and reference select codes.
  localparam logic [1:0] SMOD_SYNC_CD = 2'h0;
  localparam logic [1:0] SMOD_PLESIO  = 2'h1;
  localparam logic [1:0] SMOD_SYNC_D  = 2'h2;
  localparam logic [1:0] SMOD_LOOP    = 2'h3;
  localparam logic [1:0] REF_LOW      = 2'h0;
  localparam logic [1:0] REF_MID      = 2'h2;
  localparam logic [1:0] REF_HIGH     = 2'h3;
  // Transmit FIFO.
  localparam logic [3:0] FIFO_CENTRE = 4'h4;
  // Effective configuration, register and strap views alike.
  typedef struct packed {
    logic       lock_ctl;
    logic       loopback;
    logic       parallel_clock_mode;
    logic [1:0] smod;
    logic       monitor;
    logic [1:0] ref_sel;
    logic       par;
    logic       media_cmi;
    logic       rate_e4;
  } lmt_cfg_t;
  // Transmit timing modes.
  typedef enum logic [6:0] {
    TM_SYNC_CD   = 7'h01,
    TM_SYNC_D    = 7'h02,
    TM_PLESIO    = 7'h04,
    TM_LOOP      = 7'h08,
    TM_PAR_SLV   = 7'h10,
    TM_PAR_SLV_L = 7'h20,
    TM_PAR_MST   = 7'h40
  } lmt_tmode_t;
endpackage : lmt_pkg

// ---- verification/lmt_host_model.sv ----
// Host framer model for the serial transmit link.
// Assumes send is called off the clock edge; bit period 160 ns.
`timescale 1ns/1ps
`default_nettype none
module lmt_host_model (
  output logic o_clk,
  output logic o_dat
);
  // The clock stands still outside a nibble.
  initial begin
    o_clk = 1'h0;
    o_dat = 1'h0;
  end
  // Sends a nibble MSB first; data moves only while clock is low.
  task automatic send(input logic [3:0] nib);
    for (int k = 3; k >= 0; k--) begin
      o_dat = nib[k];
      #80 o_clk = 1'h1;
      #80 o_clk = 1'h0;
    end
    o_dat = ~nib[0]; // Idle data is the inverse, not stale.
  endtask : send
endmodule : lmt_host_model
`default_nettype wire

// ---- verification/lmt_top_chk.sv ----
// Port checker of lmt_top.
// Assumes i_ce held high.
`timescale 1ns/1ps
`default_nettype none
module lmt_top_chk
  import lmt_pkg::*;
#(
  parameter int LOL_SET = 20
) (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_rx_freq_err,
  input wire logic       i_rx_nrz_data,
  input wire logic       o_rx_signal_lost_flag,
  input wire logic       o_rx_lock_lost,
  input wire logic       o_rx_data,
  input wire logic       o_rx_clk_hold,
  input wire logic       o_rx_monitor_enable,
  input wire logic       o_cmi_enable,
  input wire logic       o_rate_e4,
  input wire logic [1:0] o_ref_freq_select,
  input wire logic       o_ref_cfg_err,
  input wire logic [6:0] o_timing_mode,
  input wire logic       o_tx_retime_rx
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  int   err_cnt;
  int   quiet_cnt;
  logic nrz_q;
  // Counts error cycles and quiet NRZ cycles.
  always_ff @(posedge i_clk) begin
    nrz_q     <= i_rx_nrz_data;
    err_cnt   <= (i_srst || !i_rx_freq_err) ? 0 : err_cnt + 1;
    quiet_cnt <= (i_srst || i_rx_nrz_data != nrz_q) ? 0 : quiet_cnt + 1;
  end
  sequence lost_s;
    o_rx_signal_lost_flag [*2];
  endsequence
  sequence mon_on_s;
    o_rx_monitor_enable [*2];
  endsequence
  squelch_hold_a: assert property (lost_s |-> !o_rx_data && o_rx_clk_hold)
    else $error("squelch broken");
  mon_needs_cmi_a: assert property (o_rx_monitor_enable |-> o_cmi_enable)
    else $error("monitor outside CMI");
  mon_no_los_a: assert property (mon_on_s |-> !o_rx_signal_lost_flag)
    else $error("loss in monitor mode");
  ref_code_err_a: assert property ((o_rate_e4 && o_ref_freq_select == REF_MID) [*2]
    |-> o_ref_cfg_err)
    else $error("bad reference not flagged");
  loop_retime_a: assert property ((o_timing_mode inside {TM_LOOP, TM_PAR_SLV_L}) [*2]
    |-> o_tx_retime_rx)
    else $error("loop not retimed");
  lol_min_time_a: assert property ($rose(o_rx_lock_lost) |-> err_cnt >= LOL_SET)
    else $error("lock lost early");
  nrz_quiet_time_a: assert property ($rose(o_rx_signal_lost_flag) && !o_cmi_enable
    |-> quiet_cnt >= QUIET_CYC)
    else $error("NRZ loss early");
  rst_idle_a: assert property (disable iff (1'h0) i_srst |=> !o_rx_signal_lost_flag
    && !o_rx_lock_lost && o_timing_mode == TM_SYNC_CD)
    else $error("not idle after reset");
endmodule : lmt_top_chk
bind lmt_top lmt_top_chk #(.LOL_SET(LOL_SET)) i_lmt_top_chk (.i_clk, .i_srst, .i_rx_freq_err,
  .i_rx_nrz_data, .o_rx_signal_lost_flag, .o_rx_lock_lost, .o_rx_data, .o_rx_clk_hold,
  .o_rx_monitor_enable, .o_cmi_enable, .o_rate_e4, .o_ref_freq_select, .o_ref_cfg_err,
  .o_timing_mode, .o_tx_retime_rx);
`default_nettype wire

// ---- verification/lmt_top_tb.sv ----
// Self-checking bench for lmt_top.
// Assumes lmt_host_model drives the host link; fixed seed.
`timescale 1ns/1ps
`default_nettype none
module lmt_top_tb;
  import lmt_pkg::*;
  localparam int LSET = 20;
  localparam int LCLR = 30;
  logic i_clk = 0, i_srst = 1, i_ce = 1, i_wr_en = 0, i_rd_en = 0, syn_on = 0, r, m, p, mo;
  logic i_hw_sw_control_select = 0, i_rate_select_pin, i_media_select_pin, i_loopback_pin;
  logic i_host_interface_select_pin, i_monitor_strap_pin, i_tx_fifo_reset_pulse = 0;
  logic i_rx_peak_low = 0, i_rx_peak_ok = 1, i_rx_nrz_data = 0, i_rx_freq_err = 0;
  logic i_rx_rec_clk = 0, i_synth_clk = 0, i_host_serial_tx_clock, i_host_serial_tx_data;
  logic o_rx_signal_lost_flag, o_rx_lock_lost, o_rx_data, o_rx_clk_hold, o_rx_monitor_enable;
  logic o_cmi_enable, o_rate_e4, o_ref_cfg_err, o_tx_retime_rx, o_tx_fifo_error, o_tx_nibble_valid;
  logic [AW-1:0] i_addr = '0;
  logic [DW-1:0] i_wr_data = '0, o_rd_data, rdat;
  logic [1:0] i_ref_freq_select, i_timing_mode_strap, o_ref_freq_select, er, ts;
  logic [3:0] i_host_tx_nibble = '0, o_tx_nibble, nib;
  logic [6:0] o_timing_mode;
  logic [10:0] d;
  logic [12:0] cfg_o, exp_c;
  int num_errors = 0, n_checks = 0, n_valid = 0;
  assign cfg_o = {o_rate_e4, o_cmi_enable, o_rx_monitor_enable, o_ref_freq_select,
    o_ref_cfg_err, o_timing_mode};
  lmt_top #(.LOL_SET(LSET), .LOL_CLR(LCLR)) i_lmt_top (.*);
  lmt_host_model i_lmt_host_model (.o_clk(i_host_serial_tx_clock), .o_dat(i_host_serial_tx_data));
  // System and line clocks.
  always #2.5 i_clk = ~i_clk;
  always #40 if (syn_on) {i_synth_clk, i_rx_rec_clk} = ~{i_synth_clk, i_rx_rec_clk};
  always @(posedge i_clk) if (o_tx_nibble_valid === 1'h1) n_valid <= n_valid + 1;
  // Expected timing modes.
  function automatic logic [6:0] exp_tm(logic par, logic pm, logic [1:0] sm);
    if (par) return pm ? TM_PAR_MST : (sm == SMOD_LOOP ? TM_PAR_SLV_L : TM_PAR_SLV);
    return 7'h01 << {sm[0], sm[1]};
  endfunction : exp_tm
  function automatic logic [6:0] exp_hw(logic par, logic [1:0] s);
    return exp_tm(par, s == STRAP_HIGH,
      {s == STRAP_FLT, s == STRAP_HIGH} | {2{par && s == STRAP_FLT}});
  endfunction : exp_hw
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wt
  task automatic hold(input int n, input logic e);
    wt(n);
    chk(o_rx_signal_lost_flag, e);
  endtask : hold
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_en <= 1'h1;
    @(posedge i_clk);
    i_wr_en <= 1'h0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [AW-1:0] a);
    i_addr <= a;
    i_rd_en <= 1'h1;
    @(posedge i_clk);
    i_rd_en <= 1'h0;
    #1 rdat = o_rd_data;
    @(posedge i_clk);
  endtask : rd
  task automatic straps();
    {r, m, p, mo, i_loopback_pin} = 5'($urandom);
    er = 2'($urandom_range(2));
    ts = 2'($urandom_range(2));
    {i_rate_select_pin, i_media_select_pin, i_host_interface_select_pin} <= {r, m, p};
    {i_monitor_strap_pin, i_ref_freq_select, i_timing_mode_strap} <= {mo, er, ts};
    er = er == STRAP_FLT ? REF_MID : (er == STRAP_HIGH ? REF_HIGH : REF_LOW);
  endtask : straps
  task automatic burst(input int n);
    repeat (n) begin
      i_rx_nrz_data <= ~i_rx_nrz_data;
      wt(2);
    end
  endtask : burst
  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // Limit well above the run.
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(55));
    straps();
    wt(10);
    chk({o_rx_signal_lost_flag, o_rx_lock_lost, o_tx_fifo_error, o_timing_mode}, 16'h001);
    i_srst <= 1'h0;
    // Straps, then registers.
    repeat (40) begin
      straps();
      wt(6);
      exp_c = {r, m, m & mo, er, r && er == REF_MID, exp_hw(p, ts)};
      chk(cfg_o, exp_c);
    end
    i_hw_sw_control_select <= 1'h1;
    wt(4);
    repeat (40) begin
      d = 11'($urandom) & 11'h3FF;
      straps();
      wr(REG_CTRL, {5'h00, d});
      wt(2);
      exp_c = {d[0], d[1], d[1] & d[5], d[4:3], d[4:3] == 2'h1 || d[0] && d[4:3] == REF_MID,
        exp_tm(d[2], d[8], d[7:6])};
      chk(cfg_o, exp_c);
      rd(REG_MODE);
      chk(rdat, {6'h00, exp_c[7], exp_c[9:8], exp_c[6:0]});
      rd(REG_CMD);
      chk(rdat, 16'h0000);
    end
    // NRZ loss set and clear.
    wr(REG_CTRL, 16'h0000);
    burst(9);
    hold(8, 1'h0);
    hold(QUIET_CYC + 20, 1'h1);
    chk(o_rx_data, 1'h0);
    burst(4);
    hold(100, 1'h1);
    wr(REG_CTRL, 16'h0200);
    hold(3, 1'h0);
    wr(REG_CTRL, 16'h0000);
    hold(QUIET_CYC + 20, 1'h1);
    burst(9);
    hold(8, 1'h0);
    // Coax loss and monitor.
    wr(REG_CTRL, 16'h0002);
    hold(LOS_STM_CYC + 20, 1'h0);
    {i_rx_peak_low, i_rx_peak_ok} <= 2'h2;
    hold(LOS_STM_CYC - 4, 1'h0);
    hold(20, 1'h1);
    wr(REG_CTRL, 16'h0022);
    hold(3, 1'h0);
    wr(REG_CTRL, 16'h0002);
    hold(LOS_STM_CYC + 20, 1'h1);
    {i_rx_peak_low, i_rx_peak_ok} <= 2'h1;
    hold(LOS_STM_CYC - 4, 1'h1);
    hold(20, 1'h0);
    // Lock set and clear.
    wr(REG_CTRL, 16'h0402);
    wr(REG_CTRL, 16'h0002);
    i_rx_freq_err <= 1'h1;
    wt(LSET - 2);
    chk(o_rx_lock_lost, 1'h0);
    wt(12);
    chk(o_rx_lock_lost, 1'h1);
    i_rx_freq_err <= 1'h0;
    wt(LCLR - 2);
    chk(o_rx_lock_lost, 1'h1);
    wt(12);
    chk(o_rx_lock_lost, 1'h0);
    // FIFO underflow and resets.
    wr(REG_CTRL, 16'h0004);
    wr(REG_CMD, 16'h0001);
    n_valid = 0;
    syn_on = 1;
    wt(200);
    syn_on = 0;
    chk({n_valid[3:0], 3'h0, o_tx_fifo_error}, 16'h41);
    wr(REG_CMD, 16'h0001);
    wt(2);
    chk(o_tx_fifo_error, 1'h0);
    syn_on = 1;
    wt(200);
    syn_on = 0;
    i_tx_fifo_reset_pulse <= 1'h1;
    wt(6);
    chk(o_tx_fifo_error, 1'h0);
    i_tx_fifo_reset_pulse <= 1'h0;
    // Plesiochronous serial nibbles.
    wr(REG_CTRL, 16'h0040);
    repeat (4) begin
      nib = 4'($urandom);
      n_valid = 0;
      i_lmt_host_model.send(nib);
      wt(10);
      chk({n_valid[3:0], o_tx_nibble}, {4'h1, nib});
    end
    end_sim();
  end
endmodule : lmt_top_tb
`default_nettype wire
